// ---- rtl/gpio_port_pkg.sv ----
/*
 * constants for the eight-pin shared gpio / lcd segment port.
 * assumes an apb master with 32-bit data; offsets are register indices, byte address = 4 * index.
 */
package gpio_port_pkg;

	localparam int PORT_W = 8;
	localparam int SEG_W = 4;
	localparam int MODE_W = 3;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] LATCH_IDX = 16'hffd9;
	localparam logic [15:0] PULLUP_IDX = 16'hffe3;
	localparam logic [15:0] DIR_IDX = 16'hffe9;
	localparam logic [15:0] LCD_CTRL_IDX = 16'hfff0;
	localparam logic [15:0] MODE_IDX = 16'hfff1;

	localparam logic [31:0] LATCH_ADDR = {14'h0000, LATCH_IDX, 2'b00};
	localparam logic [31:0] PULLUP_ADDR = {14'h0000, PULLUP_IDX, 2'b00};
	localparam logic [31:0] DIR_ADDR = {14'h0000, DIR_IDX, 2'b00};
	localparam logic [31:0] LCD_CTRL_ADDR = {14'h0000, LCD_CTRL_IDX, 2'b00};
	localparam logic [31:0] MODE_ADDR = {14'h0000, MODE_IDX, 2'b00};

	// ----------------------------------------------------------------
	// reset values and fixed read values
	// ----------------------------------------------------------------
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] PULLUP_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [3:0] SEG_RST = 4'h0;
	localparam logic [7:0] DIR_READ_VAL = 8'hff;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SEG_LSB = 0;
	localparam int MODE_LSB = 0;

	// ----------------------------------------------------------------
	// operating mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_ACTIVE = 3'h0;
	localparam logic [2:0] MODE_SUBACTIVE = 3'h1;
	localparam logic [2:0] MODE_SLEEP = 3'h2;
	localparam logic [2:0] MODE_SUBSLEEP = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h4;
	localparam logic [2:0] MODE_WATCH = 3'h5;
	localparam logic [2:0] MODE_RST = MODE_ACTIVE;

endpackage

// ---- rtl/pin_sync.sv ----
/*
 * two-stage synchroniser for the eight pin levels.
 * assumes pins are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module pin_sync
	import gpio_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [PORT_W-1:0] async_i,
	output logic [PORT_W-1:0] sync_o
);

	logic [PORT_W-1:0] meta_q;
	logic [PORT_W-1:0] sync_q;

	// only the second stage is read outside
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

// ---- rtl/pin_cell.sv ----
/*
 * one shared pin: output level, output enable and pull-up, all registered.
 * assumes mode and selection come from registers on the same clock.
 */
`timescale 1ns/1ps
module pin_cell
	import gpio_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [MODE_W-1:0] mode,
	input wire logic seg_sel,
	input wire logic dir_bit,
	input wire logic latch_bit,
	input wire logic pullup_bit,
	input wire logic seg_bit,
	output logic out_q,
	output logic oe_q,
	output logic pu_q
);

	logic out_d;
	logic oe_d;
	logic pu_d;
	logic pu_gpio;

	always_comb begin
		pu_gpio = pullup_bit & ~dir_bit;
		out_d = out_q;
		oe_d = oe_q;
		pu_d = pu_q;
		case (mode)
			MODE_SLEEP, MODE_SUBSLEEP: begin
				// hold previous state
				out_d = out_q;
			end
			MODE_STANDBY, MODE_WATCH: begin
				out_d = 1'b0;
				oe_d = 1'b0;
				pu_d = pu_gpio;
			end
			default: begin
				if (seg_sel) begin
					out_d = seg_bit;
					oe_d = 1'b1;
					pu_d = 1'b0;
				end else begin
					out_d = latch_bit;
					oe_d = dir_bit;
					pu_d = pu_gpio;
				end
			end
		endcase
	end

	// high impedance while reset is held
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
			pu_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
			pu_q <= pu_d;
		end
	end

endmodule

// ---- rtl/gpio_port.sv ----
/*
 * eight-pin gpio port shared with lcd segment outputs, registers over apb.
 * assumes an apb master on ref_clk, pin levels asynchronous, segment data from the lcd driver on ref_clk.
 */
`timescale 1ns/1ps
module gpio_port
	import gpio_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PORT_W-1:0] pin_i,
	input wire logic [PORT_W-1:0] seg_data,
	output logic [PORT_W-1:0] pin_o,
	output logic [PORT_W-1:0] pin_oe,
	output logic [PORT_W-1:0] pin_pullup
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [PORT_W-1:0] latch_q;
	logic [PORT_W-1:0] latch_d;
	logic [PORT_W-1:0] dir_q;
	logic [PORT_W-1:0] dir_d;
	logic [PORT_W-1:0] pullup_q;
	logic [PORT_W-1:0] pullup_d;
	logic [SEG_W-1:0] seg_field_q;
	logic [SEG_W-1:0] seg_field_d;
	logic [MODE_W-1:0] mode_q;
	logic [MODE_W-1:0] mode_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [PORT_W-1:0] pin_sync_lvl;
	logic [PORT_W-1:0] port_read;
	logic [31:0] rd_word;
	logic setup;
	logic wr_en;
	logic mapped;
	logic seg_sel;

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	pin_sync u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_i(pin_i),
		.sync_o(pin_sync_lvl)
	);

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// no wait state: read data is registered in setup so prdata comes from a flop
	always_comb begin
		setup = psel & ~penable;
		wr_en = psel & penable & pready_q & pwrite & ~pslverr_q & pstrb[0];
		mapped = (paddr == LATCH_ADDR) || (paddr == PULLUP_ADDR) || (paddr == DIR_ADDR) ||
			(paddr == LCD_CTRL_ADDR) || (paddr == MODE_ADDR);
		seg_sel = (seg_field_q[3:2] != 2'b00);
		port_read = (latch_q & dir_q) | (pin_sync_lvl & ~dir_q);
		rd_word = 32'h0000_0000;
		case (paddr)
			LATCH_ADDR: begin
				rd_word[PORT_W-1:0] = port_read;
			end
			PULLUP_ADDR: begin
				rd_word[PORT_W-1:0] = pullup_q;
			end
			DIR_ADDR: begin
				rd_word[PORT_W-1:0] = DIR_READ_VAL;
			end
			LCD_CTRL_ADDR: begin
				rd_word[SEG_LSB +: SEG_W] = seg_field_q;
			end
			MODE_ADDR: begin
				rd_word[MODE_LSB +: MODE_W] = mode_q;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	always_comb begin
		pready_d = setup;
		pslverr_d = setup & ~mapped;
		prdata_d = (setup & ~pwrite) ? rd_word : 32'h0000_0000;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_comb begin
		latch_d = latch_q;
		dir_d = dir_q;
		pullup_d = pullup_q;
		seg_field_d = seg_field_q;
		mode_d = mode_q;
		if (wr_en) begin
			case (paddr)
				LATCH_ADDR: begin
					latch_d = pwdata[PORT_W-1:0];
				end
				DIR_ADDR: begin
					dir_d = pwdata[PORT_W-1:0];
				end
				PULLUP_ADDR: begin
					pullup_d = pwdata[PORT_W-1:0];
				end
				LCD_CTRL_ADDR: begin
					seg_field_d = pwdata[SEG_LSB +: SEG_W];
				end
				MODE_ADDR: begin
					mode_d = pwdata[MODE_LSB +: MODE_W];
				end
				default: begin
					latch_d = latch_q;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_q <= LATCH_RST;
			dir_q <= DIR_RST;
			pullup_q <= PULLUP_RST;
			seg_field_q <= SEG_RST;
			mode_q <= MODE_RST;
		end else begin
			latch_q <= latch_d;
			dir_q <= dir_d;
			pullup_q <= pullup_d;
			seg_field_q <= seg_field_d;
			mode_q <= mode_d;
		end
	end

	// ----------------------------------------------------------------
	// per-pin drivers
	// ----------------------------------------------------------------
	// segment selection is one field for the whole port, so all pins switch together
	for (genvar i = 0; i < PORT_W; i++) begin : g_pin
		pin_cell u_cell (
			.ref_clk(ref_clk),
			.arst_n(arst_n),
			.mode(mode_q),
			.seg_sel(seg_sel),
			.dir_bit(dir_q[i]),
			.latch_bit(latch_q[i]),
			.pullup_bit(pullup_q[i]),
			.seg_bit(seg_data[i]),
			.out_q(pin_o[i]),
			.oe_q(pin_oe[i]),
			.pu_q(pin_pullup[i])
		);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic boot_q;
	logic run_mode;
	logic hiz_mode;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_q <= 1'b0;
		end else begin
			boot_q <= 1'b1;
		end
	end

	always_comb begin
		run_mode = (mode_q == MODE_ACTIVE) || (mode_q == MODE_SUBACTIVE);
		hiz_mode = (mode_q == MODE_STANDBY) || (mode_q == MODE_WATCH);
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_setup_read(logic [31:0] a);
		psel && !penable && !pwrite && (paddr == a);
	endsequence

	sequence s_sleep_held;
		(mode_q == MODE_SLEEP || mode_q == MODE_SUBSLEEP) [*2];
	endsequence

	a_latch_write_store: assert property (
		wr_en && paddr == LATCH_ADDR |=> latch_q == $past(pwdata[PORT_W-1:0]))
		else $error("latch did not take written byte");

	a_read_output_bits: assert property (
		s_setup_read(LATCH_ADDR) |=> ((prdata[PORT_W-1:0] & dir_q) == (latch_q & dir_q)) && pready)
		else $error("output bits did not read latch");

	a_read_input_bits: assert property (
		s_setup_read(LATCH_ADDR) |=>
			(prdata[PORT_W-1:0] & ~dir_q) == ($past(pin_sync_lvl) & ~dir_q))
		else $error("input bits did not read pin level");

	a_reset_regs_clear: assert property (
		!boot_q |-> latch_q == 8'h00 && dir_q == 8'h00 && pullup_q == 8'h00)
		else $error("registers not clear after reset");

	a_gpio_drive_pin: assert property (
		run_mode && !seg_sel |=> pin_oe == $past(dir_q) && pin_o == $past(latch_q))
		else $error("gpio pin not driven from latch and direction");

	a_dir_read_ones: assert property (
		s_setup_read(DIR_ADDR) |=> prdata == 32'h0000_00ff ##1 !pready)
		else $error("direction read not all ones");

	a_pullup_gate_dir: assert property (
		run_mode && !seg_sel |=> pin_pullup == ($past(pullup_q) & ~$past(dir_q)))
		else $error("pull-up not gated by direction");

	a_segment_drive_all: assert property (
		run_mode && seg_sel |=> pin_oe == 8'hff && pin_o == $past(seg_data) && pin_pullup == 8'h00)
		else $error("segment select did not drive segment data");

	a_standby_hiz_pullup: assert property (
		hiz_mode |=> pin_oe == 8'h00 && pin_pullup == ($past(pullup_q) & ~$past(dir_q)))
		else $error("standby pins not high impedance");

	a_sleep_holds_pins: assert property (
		s_sleep_held |-> $stable(pin_oe) && $stable(pin_o) && $stable(pin_pullup))
		else $error("sleep did not hold pin state");

	a_unmapped_error: assert property (
		psel && !penable && !mapped |=> pslverr && pready ##1 !pslverr)
		else $error("unmapped address not flagged");

	a_dir_write_store: assert property (
		wr_en && paddr == DIR_ADDR |=> dir_q == $past(pwdata[PORT_W-1:0]))
		else $error("direction did not take written byte");

	a_pullup_write_store: assert property (
		wr_en && paddr == PULLUP_ADDR |=> pullup_q == $past(pwdata[PORT_W-1:0]))
		else $error("pull-up control did not take written byte");

	a_strobe_off_ignored: assert property (
		psel && penable && pwrite && !pstrb[0] |=> $stable(latch_q) && $stable(dir_q) && $stable(pullup_q))
		else $error("write without low strobe changed a register");

	a_pullup_off_output: assert property (
		run_mode && !seg_sel |=> (pin_pullup & ($past(dir_q) | ~$past(pullup_q))) == 8'h00)
		else $error("pull-up on for output pin or cleared bit");

	a_reset_pins_hiz: assert property (
		!boot_q |-> pin_oe == 8'h00 && pin_pullup == 8'h00 && pin_o == 8'h00)
		else $error("pins not high impedance out of reset");

	a_read_zero_idle: assert property (
		!(psel && !penable) |=> prdata == 32'h0000_0000)
		else $error("read data not zero outside a read answer");

endmodule

// ---- verification/board_pins.sv ----
/*
 * board model for the eight shared pins: port drive, board drive, pull-up, floating.
 * assumes pin outputs of the port change on ref_clk.
 */
`timescale 1ns/1ps
module board_pins (
	input wire logic ref_clk,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_lvl
);
	logic [7:0] float_q = 8'h00;
	// a floating line toggles so a stale level never reads as valid
	always @(posedge ref_clk) begin
		float_q <= ~pin_lvl;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_lvl[i] = pin_o[i];
			else if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pin_pullup[i])
				pin_lvl[i] = 1'b1;
			else
				pin_lvl[i] = float_q[i];
		end
	end
endmodule

// ---- verification/gpio_port_tb.sv ----
/*
 * self-checking bench for the shared gpio port, apb master tasks and board model.
 * assumes the zero-wait apb slave and pin timing of the design hand-over.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("ERROR %0t %h!=%h", $time, a, e); end end
module gpio_port_tb
	import gpio_port_pkg::*;
();
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] seg_data = 8'h00;
	logic [7:0] ext_val = 8'h5a;
	logic [7:0] ext_en = 8'hff;
	logic [7:0] pin_lvl;
	logic [7:0] pin_o;
	logic [7:0] pin_oe;
	logic [7:0] pin_pullup;
	logic [31:0] rd;
	logic er;
	int n_errors = 0;
	int comparisons = 0;

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	gpio_port dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_i(pin_lvl), .seg_data(seg_data), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
	board_pins board_u (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

	// ----------------------------------------------------------------
	// bus and pin tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(n, 1)
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// pin_o only matters where the port drives
	task automatic pins(input logic [7:0] oe, input logic [7:0] pu, input logic [7:0] o);
		repeat (3) @(posedge ref_clk);
		`CHK(pin_oe, oe)
		`CHK(pin_pullup, pu)
		`CHK(pin_o & pin_oe, o)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		pins(8'h00, 8'h00, 8'h00);
		rdc(LATCH_ADDR, 32'h5a);
		rdc(PULLUP_ADDR, 32'h0);
		rdc(DIR_ADDR, 32'hff);
	endtask
	task automatic t_out();
		ext_en <= 8'h00;
		wr(DIR_ADDR, 8'hff);
		pins(8'hff, 8'h00, 8'h00);
		wr(LATCH_ADDR, 8'ha5);
		pins(8'hff, 8'h00, 8'ha5);
		rdc(LATCH_ADDR, 32'ha5);
	endtask
	task automatic t_mixed();
		ext_en <= 8'hf0;
		ext_val <= 8'hc0;
		wr(DIR_ADDR, 8'h0f);
		wr(LATCH_ADDR, 8'hff);
		pins(8'h0f, 8'h00, 8'h0f);
		rdc(LATCH_ADDR, 32'hcf);
		ext_en <= 8'h00;
		wr(PULLUP_ADDR, 8'hff);
		pins(8'h0f, 8'hf0, 8'h0f);
		rdc(LATCH_ADDR, 32'hff);
		rdc(PULLUP_ADDR, 32'hff);
	endtask
	task automatic t_seg();
		logic seg;
		seg_data <= 8'h3c;
		for (int v = 0; v < 16; v++) begin
			wr(LCD_CTRL_ADDR, 8'(v));
			seg = (v >= 4);
			pins(seg ? 8'hff : 8'h0f, seg ? 8'h00 : 8'hf0, seg ? 8'h3c : 8'h0f);
		end
		wr(LCD_CTRL_ADDR, 8'h00);
	endtask
	task automatic t_modes();
		logic [2:0] m;
		for (int k = 0; k < 2; k++) begin
			m = k ? MODE_WATCH : MODE_STANDBY;
			wr(MODE_ADDR, {5'h0, m});
			pins(8'h00, 8'hf0, 8'h00);
			m = k ? MODE_SUBSLEEP : MODE_SLEEP;
			wr(MODE_ADDR, {5'h0, MODE_ACTIVE});
			pins(8'h0f, 8'hf0, 8'h0f);
			wr(MODE_ADDR, {5'h0, m});
			wr(DIR_ADDR, 8'hf0);
			pins(8'h0f, 8'hf0, 8'h0f);
			wr(MODE_ADDR, {5'h0, MODE_SUBACTIVE});
			pins(8'hf0, 8'h0f, 8'hf0);
			wr(DIR_ADDR, 8'h0f);
		end
	endtask
	task automatic t_refuse();
		apb(1'b1, 32'h100, 32'hff);
		`CHK(er, 1'b1)
		rdc(32'h100, 32'h0);
		pstrb <= 4'h0;
		wr(LATCH_ADDR, 8'h00);
		pstrb <= 4'hf;
		rdc(LATCH_ADDR, 32'hff);
		wr(DIR_ADDR, 8'h00);
		rdc(DIR_ADDR, 32'hff);
	endtask
	// reset in mid-run must bring back the pin, pull-up and latch reset values
	task automatic t_midreset();
		ext_val <= 8'h5a;
		ext_en <= 8'hff;
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		pins(8'h00, 8'h00, 8'h00);
		rdc(PULLUP_ADDR, 32'h0);
		rdc(LATCH_ADDR, 32'h5a);
		wr(DIR_ADDR, 8'hff);
		rdc(LATCH_ADDR, 32'h0);
	endtask

	task automatic close_out();
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_out();
		t_mixed();
		t_seg();
		t_modes();
		t_refuse();
		t_midreset();
		close_out();
	end
	// far above the few hundred cycles the scenarios take
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
endmodule
